// >>> cfg_pkg.sv
// constants and types for the serial configuration slave
package cfg_pkg;
   localparam int        NUM_BYTES    = 8;
   localparam int        IDX_W        = 3;
   localparam int        OFF_W        = 7;
   localparam int        CFG_W        = NUM_BYTES * 8;
   localparam logic [6:0] SLAVE_ADDR  = 7'h6A;
   localparam int        CMD_BYTE_BIT = 7;
   localparam logic [3:0] BITS_BYTE   = 4'h8;
   localparam logic [7:0] BLOCK_COUNT = 8'h08;
   localparam logic [7:0] READ_FILL   = 8'h00;
   localparam logic [CFG_W-1:0] CFG_DEFAULTS = 64'h0000_0000_0000_0086;
   localparam int        FIFO_W       = OFF_W + 8;
   localparam int        FIFO_DEPTH   = 4;
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ADDR  = 8'h02,
      ST_ACK   = 8'h04,
      ST_CMD   = 8'h08,
      ST_COUNT = 8'h10,
      ST_WDATA = 8'h20,
      ST_TX    = 8'h40,
      ST_MACK  = 8'h80
   } link_state_type;
endpackage

// >>> cfg_stream_if.sv
// write stream between link engine, crossing fifo and register bank
`timescale 1ns/1ps
interface cfg_stream_if #(parameter int W = 15);
   logic [W-1:0] wr_data;
   logic         wr_valid;
   logic         wr_ready;
   logic [W-1:0] rd_data;
   logic         rd_valid;
   logic         rd_ready;
   modport push (output wr_data, output wr_valid, input wr_ready);
   modport pop  (input rd_data, input rd_valid, output rd_ready);
   modport fifo (input wr_data, input wr_valid, output wr_ready,
                 output rd_data, output rd_valid, input rd_ready);
endinterface

// >>> pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(parameter int W = 2) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // pins and filtered levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q, s2_q, s3_q, out_q;
         always_ff @(posedge clk) begin
            if (reset) begin
               s1_q  <= 1'b1;
               s2_q  <= 1'b1;
               s3_q  <= 1'b1;
               out_q <= 1'b1;
            end else begin
               s1_q <= d[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  out_q <= s3_q;
               end
            end
         end
         assign q[i] = out_q;
      end
   endgenerate
endmodule

// >>> async_fifo.sv
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
module async_fifo #(parameter int W = 15, parameter int DEPTH = 4) (
   // write side
   input  wire logic  wr_clk,
   input  wire logic  wr_reset,
   // read side
   input  wire logic  rd_clk,
   input  wire logic  rd_reset,
   // stream
   cfg_stream_if.fifo s
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0]  wsync1_q, wsync2_q, rsync1_q, rsync2_q;
   logic [AW:0]  wbin_d, rbin_d;
   logic         push, pop;

   assign s.wr_ready = (wgray_q != {~rsync2_q[AW:AW-1], rsync2_q[AW-2:0]});
   assign s.rd_valid = (rgray_q != wsync2_q);
   assign s.rd_data  = mem_q[rbin_q[AW-1:0]];
   assign push   = s.wr_valid & s.wr_ready;
   assign pop    = s.rd_valid & s.rd_ready;
   assign wbin_d = wbin_q + (AW+1)'(1);
   assign rbin_d = rbin_q + (AW+1)'(1);

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem_q[wbin_q[AW-1:0]] <= s.wr_data;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (wr_reset) begin
         wbin_q   <= '0;
         wgray_q  <= '0;
         rsync1_q <= '0;
         rsync2_q <= '0;
      end else begin
         rsync1_q <= rgray_q;
         rsync2_q <= rsync1_q;
         if (push) begin
            wbin_q  <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
         end
      end
   end

   always_ff @(posedge rd_clk) begin
      if (rd_reset) begin
         rbin_q   <= '0;
         rgray_q  <= '0;
         wsync1_q <= '0;
         wsync2_q <= '0;
      end else begin
         wsync1_q <= wgray_q;
         wsync2_q <= wsync1_q;
         if (pop) begin
            rbin_q  <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
         end
      end
   end
endmodule

// >>> cfg_serial_slave.sv
// two-wire configuration slave: link engine, crossing and register bank
`timescale 1ns/1ps
module cfg_serial_slave
   import cfg_pkg::*;
(
   // system clock domain
   input  wire logic                 clk,
   input  wire logic                 reset,
   // link clock domain
   input  wire logic                 link_clk,
   input  wire logic                 link_reset,
   // serial pins
   input  wire logic                 serial_clock_line,
   input  wire logic                 serial_data_line_in,
   output logic                      serial_data_line_out,
   output logic                      serial_data_line_oe,
   // configuration side
   input  wire logic                 update_hold,
   output logic [cfg_pkg::CFG_W-1:0] cfg_bytes
);
   import cfg_pkg::*;

   link_state_type    state_q, next_q, after_ack;
   logic [1:0]        pins_s;
   logic              scl_s, sda_s, scl_p_q, sda_p_q;
   logic              scl_rise, scl_fall, start_ev, stop_ev;
   logic [3:0]        bit_cnt_q;
   logic [7:0]        shift_q, tx_q, rd_byte;
   logic [OFF_W-1:0]  ptr_q;
   logic              cnt_pending_q, sda_oe_q, sda_out_q, push_q;
   logic [FIFO_W-1:0] push_data_q;
   logic              receiving, byte_done, ack_byte, addr_hit, ptr_in_range;
   logic [7:0]        mirror_q [NUM_BYTES];
   logic [7:0]        cfg_q [NUM_BYTES];
   logic [OFF_W-1:0]  pop_off;

   cfg_stream_if #(.W(FIFO_W)) stream ();

   pin_sync #(.W(2)) u_pins (
      .clk   (link_clk),
      .reset (link_reset),
      .d     ({serial_clock_line, serial_data_line_in}),
      .q     (pins_s)
   );

   async_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wr_clk   (link_clk),
      .wr_reset (link_reset),
      .rd_clk   (clk),
      .rd_reset (reset),
      .s        (stream.fifo)
   );

   // edge and condition detection
   assign scl_s    = pins_s[1];
   assign sda_s    = pins_s[0];
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign receiving    = (state_q == ST_ADDR) | (state_q == ST_CMD) |
                         (state_q == ST_COUNT) | (state_q == ST_WDATA);
   assign byte_done    = receiving & scl_fall & (bit_cnt_q == BITS_BYTE);
   assign addr_hit     = (shift_q[7:1] == SLAVE_ADDR);
   assign ptr_in_range = (ptr_q < OFF_W'(NUM_BYTES));
   assign rd_byte      = ptr_in_range ? mirror_q[ptr_q[IDX_W-1:0]] : READ_FILL;

   // acknowledge decision per received byte
   always_comb begin
      ack_byte  = 1'b1;
      after_ack = ST_IDLE;
      case (state_q)
         ST_ADDR: begin
            ack_byte  = addr_hit;
            after_ack = shift_q[0] ? ST_TX : ST_CMD;
         end
         ST_CMD: begin
            after_ack = shift_q[CMD_BYTE_BIT] ? ST_WDATA : ST_COUNT;
         end
         ST_COUNT: begin
            after_ack = ST_WDATA;
         end
         ST_WDATA: begin
            ack_byte  = stream.wr_ready;
            after_ack = ST_WDATA;
         end
         default: begin
            ack_byte  = 1'b0;
            after_ack = ST_IDLE;
         end
      endcase
   end

   // protocol sequencer
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         state_q   <= ST_IDLE;
         next_q    <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         sda_oe_q  <= 1'b0;
      end else if (start_ev) begin
         state_q   <= ST_ADDR;
         bit_cnt_q <= 4'h0;
         sda_oe_q  <= 1'b0;
      end else if (stop_ev) begin
         state_q  <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_q <= 4'h0;
                  if (ack_byte) begin
                     sda_oe_q <= 1'b1;
                     state_q  <= ST_ACK;
                     next_q   <= after_ack;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_q  <= next_q;
                  sda_oe_q <= (next_q == ST_TX) & ~tx_q[7];
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_q == BITS_BYTE) begin
                     sda_oe_q  <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     state_q   <= ST_MACK;
                  end else begin
                     sda_oe_q <= ~tx_q[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_ACK;
                     next_q  <= ST_TX;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // receive shifter
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         shift_q <= 8'h00;
      end else if (receiving & scl_rise) begin
         shift_q <= {shift_q[6:0], sda_s};
      end
   end

   // offset pointer, count flag and transmit byte
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         ptr_q         <= '0;
         cnt_pending_q <= 1'b0;
         tx_q          <= 8'h00;
      end else if (byte_done & (state_q == ST_CMD)) begin
         ptr_q         <= shift_q[OFF_W-1:0];
         cnt_pending_q <= ~shift_q[CMD_BYTE_BIT];
      end else if (byte_done & (state_q == ST_WDATA) & stream.wr_ready) begin
         ptr_q <= ptr_q + OFF_W'(1);
      end else if ((byte_done & (state_q == ST_ADDR) & addr_hit & shift_q[0]) |
                   ((state_q == ST_MACK) & scl_rise & ~sda_s)) begin
         if (cnt_pending_q) begin
            tx_q          <= BLOCK_COUNT;
            cnt_pending_q <= 1'b0;
         end else begin
            tx_q  <= rd_byte;
            ptr_q <= ptr_q + OFF_W'(1);
         end
      end else if ((state_q == ST_TX) & scl_fall & (bit_cnt_q != BITS_BYTE)) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // link-side copy of the configuration for reads
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            mirror_q[i] <= CFG_DEFAULTS[i*8 +: 8];
         end
      end else if (byte_done & (state_q == ST_WDATA) & stream.wr_ready & ptr_in_range) begin
         mirror_q[ptr_q[IDX_W-1:0]] <= shift_q;
      end
   end

   // write stream towards the system domain
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         push_q      <= 1'b0;
         push_data_q <= '0;
      end else begin
         push_q <= byte_done & (state_q == ST_WDATA) & stream.wr_ready;
         if (byte_done & (state_q == ST_WDATA)) begin
            push_data_q <= {ptr_q, shift_q};
         end
      end
   end

   assign stream.wr_valid = push_q;
   assign stream.wr_data  = push_data_q;

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= 1'b0;
      end
   end

   assign serial_data_line_out = sda_out_q;
   assign serial_data_line_oe  = sda_oe_q;

   // system-side configuration bank
   assign stream.rd_ready = ~update_hold;
   assign pop_off         = stream.rd_data[FIFO_W-1:8];

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            cfg_q[i] <= CFG_DEFAULTS[i*8 +: 8];
         end
      end else if (stream.rd_valid & stream.rd_ready & (pop_off < OFF_W'(NUM_BYTES))) begin
         cfg_q[pop_off[IDX_W-1:0]] <= stream.rd_data[7:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_BYTES; g++) begin : g_cfg
         assign cfg_bytes[g*8 +: 8] = cfg_q[g];
      end
   endgenerate

   // checks
   sequence seq_byte_in(link_state_type st);
      (state_q == st) && scl_fall && (bit_cnt_q == BITS_BYTE);
   endsequence

   chk_addr_match_ack: assert property (@(posedge link_clk) disable iff (link_reset)
      (seq_byte_in(ST_ADDR) and (addr_hit && !start_ev && !stop_ev))
      |=> sda_oe_q && (state_q == ST_ACK))
      else $error("matched address not acknowledged");

   chk_addr_miss_free: assert property (@(posedge link_clk) disable iff (link_reset)
      (seq_byte_in(ST_ADDR) and (!addr_hit && !start_ev && !stop_ev))
      |=> !sda_oe_q && (state_q == ST_IDLE))
      else $error("foreign address drove the data line");

   chk_cmd_mode_sel: assert property (@(posedge link_clk) disable iff (link_reset)
      (seq_byte_in(ST_CMD) and (!start_ev && !stop_ev))
      |=> next_q == ($past(shift_q[CMD_BYTE_BIT]) ? ST_WDATA : ST_COUNT))
      else $error("command mode decoded wrongly");

   chk_cmd_offset: assert property (@(posedge link_clk) disable iff (link_reset)
      seq_byte_in(ST_CMD) |=> ptr_q == $past(shift_q[OFF_W-1:0]))
      else $error("offset not taken from command");

   chk_write_push: assert property (@(posedge link_clk) disable iff (link_reset)
      (seq_byte_in(ST_WDATA) and (stream.wr_ready && !start_ev && !stop_ev))
      |=> push_q && sda_oe_q && (ptr_q == $past(ptr_q) + OFF_W'(1)))
      else $error("data byte not pushed and acknowledged");

   chk_ack_release: assert property (@(posedge link_clk) disable iff (link_reset)
      (state_q == ST_ACK) && scl_fall && (next_q != ST_TX) && !start_ev && !stop_ev
      |=> !sda_oe_q)
      else $error("acknowledge held past its bit");

   chk_count_first: assert property (@(posedge link_clk) disable iff (link_reset)
      (seq_byte_in(ST_ADDR) and (addr_hit && shift_q[0] && cnt_pending_q))
      |=> tx_q == BLOCK_COUNT)
      else $error("block read did not start with the count");

   chk_master_nack: assert property (@(posedge link_clk) disable iff (link_reset)
      (state_q == ST_MACK) && scl_rise && sda_s && !start_ev && !stop_ev
      |=> (state_q == ST_IDLE) && !sda_oe_q [*2])
      else $error("slave kept sending after no-ack");

   chk_cfg_update: assert property (@(posedge clk) disable iff (reset)
      stream.rd_valid && stream.rd_ready && (pop_off == OFF_W'(0))
      |=> cfg_bytes[7:0] == $past(stream.rd_data[7:0]))
      else $error("configuration byte not updated");

   chk_cfg_default: assert property (@(posedge clk)
      reset |=> cfg_bytes == CFG_DEFAULTS)
      else $error("configuration default wrong after reset");
endmodule

// >>> serial_master_model.sv
// two-wire bus master model for the configuration slave
`timescale 1ns/1ps
module serial_master_model (
   // timing reference
   input  wire logic       link_clk,
   // resolved data level
   input  wire logic       sda_level,
   // pin drives
   output logic            scl,
   output logic            sda_low,
   // byte seen with its ack level
   output logic            seen_pulse,
   output logic [8:0]      seen_val
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      seen_pulse = 1'b0;
      seen_val = 9'h000;
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // start or repeated start, clock left low
   task automatic start();
      wait_n(2);
      sda_low <= 1'b0;
      wait_n(5);
      scl <= 1'b1;
      wait_n(7);
      sda_low <= 1'b1;
      wait_n(7);
      scl <= 1'b0;
   endtask
   // stop, bus left idle
   task automatic stop();
      wait_n(2);
      sda_low <= 1'b1;
      wait_n(5);
      scl <= 1'b1;
      wait_n(7);
      sda_low <= 1'b0;
      wait_n(7);
   endtask
   // data set while clock low, sampled late in clock high
   task automatic bit_io(input logic b, output logic s);
      wait_n(2);
      sda_low <= ~b;
      wait_n(5);
      scl <= 1'b1;
      wait_n(6);
      @(negedge link_clk);
      s = sda_level;
      @(posedge link_clk);
      scl <= 1'b0;
   endtask
   // one byte msb first, then ack slot; on reads mack is the level given
   task automatic xfer(input logic [7:0] tx, input logic rd, input logic mack);
      logic [8:0] v;
      logic       s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(rd ? 1'b1 : tx[i], s);
         v[i] = s;
      end
      bit_io(rd ? mack : 1'b1, s);
      v[8] = s;
      seen_val = v;
      seen_pulse <= 1'b1;
      @(posedge link_clk);
      seen_pulse <= 1'b0;
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the serial configuration slave
`timescale 1ns/1ps
module testbench;
   import cfg_pkg::*;
   logic             clk;
   logic             reset;
   logic             link_clk;
   logic             link_reset;
   logic             update_hold;
   logic             scl;
   logic             sda_low;
   logic             sda_level;
   logic             sda_out;
   logic             sda_oe;
   logic             seen_pulse;
   logic [8:0]       seen_val;
   logic [CFG_W-1:0] cfg_bytes;
   logic [CFG_W-1:0] model_q;
   logic [8:0]       exp_q[$];
   logic [7:0]       off;
   logic [7:0]       dat;
   int               fail_count;
   int               compares;

   // pulled-up data line, low when either side pulls
   assign sda_level = ~(sda_low | (sda_oe & ~sda_out));

   cfg_serial_slave dut_u (
      .clk(clk), .reset(reset), .link_clk(link_clk), .link_reset(link_reset),
      .serial_clock_line(scl), .serial_data_line_in(sda_level),
      .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
      .update_hold(update_hold), .cfg_bytes(cfg_bytes)
   );
   serial_master_model m_u (
      .link_clk(link_clk), .sda_level(sda_level), .scl(scl), .sda_low(sda_low),
      .seen_pulse(seen_pulse), .seen_val(seen_val)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   initial begin
      reset = 1'b1;
      update_hold = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
   end
   initial begin
      link_reset = 1'b1;
      repeat (6) @(posedge link_clk);
      link_reset <= 1'b0;
   end

   task automatic end_sim();
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // note expected byte and ack level, then run the byte on the link
   task automatic op(input logic [7:0] tx, input logic rd, input logic a, input logic [7:0] b);
      exp_q.push_back({a, rd ? b : tx});
      m_u.xfer(rd ? 8'hFF : tx, rd, a);
   endtask
   task automatic wait_cfg();
      for (int i = 0; i < 400 && cfg_bytes !== model_q; i++) @(posedge clk);
      check("cfg_bytes", cfg_bytes, model_q);
   endtask

   // compares each finished link byte with the oldest note
   always @(posedge seen_pulse) begin
      check("link note", 64'(exp_q.size() != 0), 64'h1);
      if (exp_q.size() != 0)
         check("link byte", seen_val, exp_q.pop_front());
   end

   initial begin
      repeat (95000) @(posedge clk);
      fail_count++;
      end_sim();
   end

   initial begin
      void'($urandom(55662));
      fail_count = 0;
      compares = 0;
      model_q = CFG_DEFAULTS;
      wait (!reset && !link_reset);
      repeat (8) @(posedge link_clk);
      check("defaults", cfg_bytes, CFG_DEFAULTS);
      // foreign address left unanswered
      m_u.start();
      op(8'hD6, 1'b0, 1'b1, 8'h00);
      m_u.stop();
      // single-byte writes at random offsets, the last beyond the bank
      for (int k = 0; k < 3; k++) begin
         off = (k == 2) ? 8'h0A : 8'($urandom_range(7));
         dat = 8'($urandom);
         m_u.start();
         op(8'hD4, 1'b0, 1'b0, 8'h00);
         op(8'h80 | off, 1'b0, 1'b0, 8'h00);
         op(dat, 1'b0, 1'b0, 8'h00);
         m_u.stop();
         if (k < 2)
            model_q[int'(off)*8 +: 8] = dat;
         wait_cfg();
      end
      // single-byte reads, one beyond the bank
      for (int k = 0; k < 2; k++) begin
         off = k ? 8'h0A : 8'($urandom_range(7));
         dat = k ? READ_FILL : model_q[int'(off[2:0])*8 +: 8];
         m_u.start();
         op(8'hD4, 1'b0, 1'b0, 8'h00);
         op(8'h80 | off, 1'b0, 1'b0, 8'h00);
         m_u.start();
         op(8'hD5, 1'b0, 1'b0, 8'h00);
         op(8'h00, 1'b1, 1'b1, dat);
         m_u.stop();
      end
      // block write of every byte
      m_u.start();
      op(8'hD4, 1'b0, 1'b0, 8'h00);
      op(8'h00, 1'b0, 1'b0, 8'h00);
      op(BLOCK_COUNT, 1'b0, 1'b0, 8'h00);
      for (int i = 0; i < NUM_BYTES; i++) begin
         dat = 8'($urandom);
         op(dat, 1'b0, 1'b0, 8'h00);
         model_q[i*8 +: 8] = dat;
      end
      m_u.stop();
      wait_cfg();
      // block read back, last byte not acknowledged
      m_u.start();
      op(8'hD4, 1'b0, 1'b0, 8'h00);
      op(8'h00, 1'b0, 1'b0, 8'h00);
      m_u.start();
      op(8'hD5, 1'b0, 1'b0, 8'h00);
      op(8'h00, 1'b1, 1'b0, BLOCK_COUNT);
      for (int i = 0; i < NUM_BYTES; i++)
         op(8'h00, 1'b1, 1'(i == NUM_BYTES - 1), model_q[i*8 +: 8]);
      m_u.stop();
      // drain stalled: fifo fills, next byte refused
      @(posedge clk);
      update_hold <= 1'b1;
      m_u.start();
      op(8'hD4, 1'b0, 1'b0, 8'h00);
      op(8'h00, 1'b0, 1'b0, 8'h00);
      op(BLOCK_COUNT, 1'b0, 1'b0, 8'h00);
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         dat = 8'($urandom);
         op(dat, 1'b0, 1'(i == FIFO_DEPTH), 8'h00);
         if (i < FIFO_DEPTH)
            model_q[i*8 +: 8] = dat;
      end
      m_u.stop();
      @(posedge clk);
      update_hold <= 1'b0;
      wait_cfg();
      repeat (4) @(posedge link_clk);
      check("pending notes", 64'(exp_q.size()), 64'h0);
      end_sim();
   end
endmodule
